// file: asu_map.svh
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define ASU_MODE_OFF    3'h0
`define ASU_MODE_7BIT   3'h4
`define ASU_MODE_8BIT   3'h5
`define ASU_MODE_9BIT   3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASU_OVERSAMPLE  5'h10
`define ASU_SAMPLE_MID  4'h7
`define ASU_CLK_HZ      10000000
`define ASU_FIFO_DEPTH  8

`endif

// file: asu_pkg.sv
package asu_pkg;
  typedef enum logic [1:0] {ASU_TX_IDLE, ASU_TX_START, ASU_TX_BITS, ASU_TX_STOP} asu_tx_e;
  typedef enum logic [1:0] {ASU_RX_IDLE, ASU_RX_START, ASU_RX_BITS, ASU_RX_STOP} asu_rx_e;
  typedef logic [8:0] asu_char_t;
endpackage

// file: asu_fifo.sv
`timescale 1ns/100ps
module asu_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // asu_fifo

// file: asu_uart.sv
`timescale 1ns/100ps
`include "asu_map.svh"

module asu_uart (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Configuration
  input  wire logic [2:0]            serial_mode_field,
  input  wire logic                  clock_source_select,
  input  wire logic                  internal_tap_tick,
  input  wire logic [7:0]            baud_divisor,
  input  wire logic                  stop_bit_select,
  input  wire logic                  parity_enable,
  input  wire logic                  parity_odd_even_select,
  input  wire logic                  pin_polarity_invert,
  input  wire logic                  data_logic_invert,
  input  wire logic                  bit_order_select,
  input  wire logic                  open_drain_select,
  input  wire logic                  rx_filter_enable,
  input  wire logic                  handshake_disable,
  input  wire logic                  handshake_select,
  input  wire logic                  tx_irq_source_select,
  input  wire logic                  transmit_enable,
  input  wire logic                  rx_enable,
  // Transmit data
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire asu_pkg::asu_char_t    transmit_buffer,
  output logic                       tx_buffer_empty_flag,
  output logic                       tx_shift_empty,
  // Receive data
  output asu_pkg::asu_char_t         receive_buffer,
  output logic                       rx_complete_flag,
  input  wire logic                  rx_read,
  output logic                       overrun_flag,
  output logic                       framing_error_flag,
  output logic                       parity_error_flag,
  output logic                       error_sum_flag,
  // Interrupt requests
  output logic                       tx_irq,
  output logic                       rx_irq_control,
  // Pins
  output logic                       serial_out_pin_o,
  output logic                       serial_out_pin_oe,
  input  wire logic                  serial_in_pin,
  input  wire logic                  transfer_clock_pin,
  input  wire logic                  handshake_pin_i,
  output logic                       handshake_pin_o,
  output logic                       handshake_pin_oe
);
  import asu_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] rxd_sync;
  logic [2:0] clk_sync;
  logic [2:0] cts_sync;
  logic       rxd_s;
  logic       clkp_s;
  logic       cts_s;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxd_sync <= 3'h7;
      clk_sync <= 3'h7;
      cts_sync <= 3'h7;
      rxd_s    <= 1'b1;
      clkp_s   <= 1'b1;
      cts_s    <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[1:0], serial_in_pin};
      clk_sync <= {clk_sync[1:0], transfer_clock_pin};
      cts_sync <= {cts_sync[1:0], handshake_pin_i};
      if (rxd_sync[1] == rxd_sync[2]) begin
        rxd_s <= rxd_sync[2];
      end
      if (clk_sync[1] == clk_sync[2]) begin
        clkp_s <= clk_sync[2];
      end
      if (cts_sync[1] == cts_sync[2]) begin
        cts_s <= cts_sync[2];
      end
    end
  end

  logic clkp_d;
  logic clkp_rise;
  logic clkp_fall;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkp_d <= 1'b1;
    end else begin
      clkp_d <= clkp_s;
    end
  end
  assign clkp_rise = clkp_s & ~clkp_d;
  assign clkp_fall = ~clkp_s & clkp_d;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic       mode_on;
  logic [3:0] nbits;
  logic       msb_first;
  assign mode_on = (serial_mode_field == `ASU_MODE_7BIT) |
                   (serial_mode_field == `ASU_MODE_8BIT) |
                   (serial_mode_field == `ASU_MODE_9BIT);
  always_comb begin
    unique case (serial_mode_field)
      `ASU_MODE_7BIT: nbits = 4'h7;
      `ASU_MODE_9BIT: nbits = 4'h9;
      default:        nbits = 4'h8;
    endcase
  end
  assign msb_first = bit_order_select & (serial_mode_field == `ASU_MODE_8BIT);

  // ----------------------------------------
  // Baud divider: source tick / (n+1) = 16x tick
  // ----------------------------------------
  logic       src_tick;
  logic [7:0] brg_cnt;
  logic       os_tick;
  assign src_tick = clock_source_select ? clkp_rise : internal_tap_tick;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brg_cnt <= 8'h00;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (!mode_on) begin
        brg_cnt <= baud_divisor;
      end else if (src_tick) begin
        if (brg_cnt == 8'h00) begin
          brg_cnt <= baud_divisor;
          os_tick <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Receive filter on the 16x tick
  // ----------------------------------------
  logic [2:0] flt;
  logic       flt_out;
  logic       rx_line;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt     <= 3'h7;
      flt_out <= 1'b1;
    end else if (os_tick) begin
      flt <= {flt[1:0], rxd_s};
      if (flt[1:0] == {2{rxd_s}} && flt[1] == rxd_s) begin
        flt_out <= rxd_s;
      end
    end
  end
  assign rx_line = (rx_filter_enable ? flt_out : rxd_s) ^ pin_polarity_invert;

  // ----------------------------------------
  // Transmit buffer FIFO
  // ----------------------------------------
  logic      fifo_valid;
  logic      fifo_pop;
  asu_char_t fifo_data;
  asu_fifo #(.WIDTH(9), .DEPTH(`ASU_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (transmit_buffer),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  assign tx_buffer_empty_flag = ~fifo_valid;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  asu_tx_e   tx_st;
  asu_char_t tx_sh;
  logic [3:0] tx_os;
  logic [3:0] tx_cnt;
  logic      tx_par;
  logic      tx_bit;
  logic      cts_on;
  logic      tx_go;
  logic      tx_end;
  logic [3:0] tx_last;

  assign cts_on = ~handshake_disable & ~handshake_select;
  assign tx_go  = mode_on & transmit_enable & fifo_valid &
                  (~cts_on | ~cts_s);
  assign tx_last = nbits + {3'h0, parity_enable};
  assign fifo_pop = (tx_st == ASU_TX_IDLE) & tx_go;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_st  <= ASU_TX_IDLE;
      tx_sh  <= 9'h000;
      tx_os  <= 4'h0;
      tx_cnt <= 4'h0;
      tx_par <= 1'b0;
      tx_bit <= 1'b1;
      tx_end <= 1'b0;
    end else begin
      tx_end <= 1'b0;
      if (!mode_on) begin
        tx_st  <= ASU_TX_IDLE;
        tx_bit <= 1'b1;
      end else begin
        unique case (tx_st)
          ASU_TX_IDLE: begin
            tx_bit <= 1'b1;
            if (tx_go) begin
              tx_sh  <= data_logic_invert ? ~fifo_data : fifo_data;
              tx_st  <= ASU_TX_START;
              tx_os  <= 4'h0;
              tx_bit <= 1'b0;
            end
          end
          ASU_TX_START: if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == 4'hF) begin
              tx_st  <= ASU_TX_BITS;
              tx_cnt <= 4'h0;
              tx_bit <= msb_first ? tx_sh[7] : tx_sh[0];
              tx_par <= (msb_first ? tx_sh[7] : tx_sh[0]) ^ ~parity_odd_even_select;
            end
          end
          ASU_TX_BITS: if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == 4'hF) begin
              tx_cnt <= tx_cnt + 4'h1;
              if (tx_cnt + 4'h1 == tx_last) begin
                tx_st  <= ASU_TX_STOP;
                tx_cnt <= 4'h0;
                tx_bit <= 1'b1;
              end else if (tx_cnt + 4'h1 == nbits) begin
                tx_bit <= tx_par;
              end else begin
                if (msb_first) begin
                  tx_sh  <= {tx_sh[8], tx_sh[6:0], 1'b0};
                  tx_bit <= tx_sh[6];
                  tx_par <= tx_par ^ tx_sh[6];
                end else begin
                  tx_sh  <= {1'b0, tx_sh[8:1]};
                  tx_bit <= tx_sh[1];
                  tx_par <= tx_par ^ tx_sh[1];
                end
              end
            end
          end
          ASU_TX_STOP: if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == 4'hF) begin
              if (stop_bit_select && tx_cnt == 4'h0) begin
                tx_cnt <= 4'h1;
              end else begin
                tx_st  <= ASU_TX_IDLE;
                tx_end <= 1'b1;
              end
            end
          end
          default: tx_st <= ASU_TX_IDLE;
        endcase
      end
    end
  end

  assign tx_shift_empty = (tx_st == ASU_TX_IDLE);
  assign tx_irq = tx_irq_source_select ? tx_end : fifo_pop;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serial_out_pin_o  <= 1'b1;
      serial_out_pin_oe <= 1'b0;
    end else begin
      serial_out_pin_o  <= tx_bit ^ pin_polarity_invert;
      serial_out_pin_oe <= mode_on &
                           ~(open_drain_select & (tx_bit ^ pin_polarity_invert));
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  asu_rx_e    rx_st;
  asu_char_t  rx_sh;
  logic [3:0] rx_os;
  logic [3:0] rx_cnt;
  logic       rx_par;
  logic       rx_ferr;
  logic       rx_ovr_chk;
  logic       rx_done;
  logic       mid;
  assign mid = os_tick & (rx_os == `ASU_SAMPLE_MID);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_st   <= ASU_RX_IDLE;
      rx_sh   <= 9'h000;
      rx_os   <= 4'h0;
      rx_cnt  <= 4'h0;
      rx_par  <= 1'b0;
      rx_ferr <= 1'b0;
      rx_done <= 1'b0;
      rx_ovr_chk <= 1'b0;
    end else begin
      rx_done    <= 1'b0;
      rx_ovr_chk <= 1'b0;
      if (os_tick) begin
        rx_os <= rx_os + 4'h1;
      end
      if (!mode_on || !rx_enable) begin
        rx_st <= ASU_RX_IDLE;
      end else begin
        unique case (rx_st)
          ASU_RX_IDLE: if (os_tick && !rx_line) begin
            rx_st <= ASU_RX_START;
            rx_os <= 4'h1;
          end
          ASU_RX_START: if (mid) begin
            if (rx_line) begin
              rx_st <= ASU_RX_IDLE;
            end else begin
              rx_st   <= ASU_RX_BITS;
              rx_cnt  <= 4'h0;
              rx_sh   <= 9'h000;
              rx_par  <= ~parity_odd_even_select;
              rx_ferr <= 1'b0;
            end
          end
          ASU_RX_BITS: if (mid) begin
            rx_cnt <= rx_cnt + 4'h1;
            rx_par <= rx_par ^ rx_line;
            if (rx_cnt < nbits) begin
              if (msb_first) begin
                rx_sh <= {1'b0, rx_sh[6:0], rx_line};
              end else begin
                rx_sh[rx_cnt] <= rx_line;
              end
            end
            if (rx_cnt + 4'h1 == tx_last) begin
              rx_st  <= ASU_RX_STOP;
              rx_cnt <= 4'h0;
              rx_ovr_chk <= ~stop_bit_select;
            end
          end
          ASU_RX_STOP: if (mid) begin
            if (!rx_line) begin
              rx_ferr <= 1'b1;
            end
            if (stop_bit_select && rx_cnt == 4'h0) begin
              rx_cnt     <= 4'h1;
              rx_ovr_chk <= 1'b1;
            end else begin
              rx_st   <= ASU_RX_IDLE;
              rx_done <= 1'b1;
            end
          end
          default: rx_st <= ASU_RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Receive buffer and flags
  // ----------------------------------------
  logic ovr_now;
  assign ovr_now = rx_ovr_chk & rx_complete_flag & ~rx_read;
  assign error_sum_flag = overrun_flag | framing_error_flag | parity_error_flag;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      receive_buffer     <= 9'h000;
      rx_complete_flag   <= 1'b0;
      overrun_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      rx_irq_control     <= 1'b0;
    end else begin
      rx_irq_control <= 1'b0;
      if (!mode_on) begin
        overrun_flag       <= 1'b0;
        framing_error_flag <= 1'b0;
        parity_error_flag  <= 1'b0;
        rx_complete_flag   <= 1'b0;
      end else begin
        if (rx_done) begin
          receive_buffer     <= data_logic_invert ? ~rx_sh : rx_sh;
          framing_error_flag <= rx_ferr;
          parity_error_flag  <= parity_enable & rx_par;
        end
        if (ovr_now) begin
          overrun_flag <= 1'b1;
        end
        if (rx_done) begin
          rx_complete_flag <= 1'b1;
          rx_irq_control   <= ~(overrun_flag | ovr_now);
        end else if (rx_read) begin
          rx_complete_flag <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Handshake pin
  // ----------------------------------------
  logic rts_low;
  logic rts_hold;
  // Stays high after a clock fall until the buffer is read or the receiver is off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_hold <= 1'b0;
    end else if (clkp_fall) begin
      rts_hold <= 1'b1;
    end else if (rx_read || !mode_on || !rx_enable) begin
      rts_hold <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_low <= 1'b0;
    end else if (clkp_fall) begin
      rts_low <= 1'b0;
    end else if (mode_on && rx_enable && !rx_complete_flag && !rts_hold) begin
      rts_low <= 1'b1;
    end else begin
      rts_low <= 1'b0;
    end
  end
  assign handshake_pin_o  = ~rts_low;
  assign handshake_pin_oe = ~handshake_disable & handshake_select;
endmodule // asu_uart

// file: asu_uart_props.sv
`timescale 1ns/100ps
`include "asu_map.svh"
module asu_uart_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Settings
  input wire logic [2:0] serial_mode_field,
  input wire logic       transmit_enable,
  input wire logic       pin_polarity_invert,
  input wire logic       handshake_disable,
  input wire logic       handshake_select,
  input wire logic       tx_irq_source_select,
  // Status and pins
  input wire logic       tx_shift_empty,
  input wire logic       rx_complete_flag,
  input wire logic       overrun_flag,
  input wire logic       framing_error_flag,
  input wire logic       parity_error_flag,
  input wire logic       error_sum_flag,
  input wire logic       tx_irq,
  input wire logic       rx_irq_control,
  input wire logic       serial_out_pin_o,
  input wire logic       handshake_pin_i,
  input wire logic       handshake_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------
  // Properties
  // ----------------
  property p_idle;
    tx_shift_empty && !pin_polarity_invert && !$past(pin_polarity_invert) |-> serial_out_pin_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle line low");
  property p_sum;
    error_sum_flag == (overrun_flag || framing_error_flag || parity_error_flag);
  endproperty
  a_sum: assert property (p_sum) else $error("error sum wrong");
  property p_ten;
    !transmit_enable && tx_shift_empty |=> tx_shift_empty;
  endproperty
  a_ten: assert property (p_ten) else $error("send while disabled");
  property p_cts;
    (!handshake_disable && !handshake_select && handshake_pin_i && tx_shift_empty) [*5]
      |=> tx_shift_empty;
  endproperty
  a_cts: assert property (p_cts) else $error("send while not clear");
  property p_oe;
    serial_mode_field != `ASU_MODE_OFF |->
      handshake_pin_oe == (!handshake_disable && handshake_select);
  endproperty
  a_oe: assert property (p_oe) else $error("handshake enable wrong");
  property p_irq0;
    tx_irq && !tx_irq_source_select |=> !tx_shift_empty;
  endproperty
  a_irq0: assert property (p_irq0) else $error("load irq without load");
  property p_rxirq;
    rx_irq_control |-> ##[0:1] rx_complete_flag;
  endproperty
  a_rxirq: assert property (p_rxirq) else $error("rx irq without data");
  property p_off;
    serial_mode_field == `ASU_MODE_OFF |=>
      !overrun_flag && !framing_error_flag && !parity_error_flag;
  endproperty
  a_off: assert property (p_off) else $error("flags kept when off");
  c_txi: cover property (tx_irq);
  c_rxi: cover property (rx_irq_control);
  c_ovr: cover property ($rose(overrun_flag));
endmodule // asu_uart_props

bind asu_uart asu_uart_props u_props (
  .clk, .nrst, .serial_mode_field, .transmit_enable, .pin_polarity_invert,
  .handshake_disable, .handshake_select, .tx_irq_source_select, .tx_shift_empty,
  .rx_complete_flag, .overrun_flag, .framing_error_flag, .parity_error_flag,
  .error_sum_flag, .tx_irq, .rx_irq_control, .serial_out_pin_o, .handshake_pin_i,
  .handshake_pin_oe
);

// file: asu_peer.sv
`timescale 1ns/100ps
module asu_peer #(
  parameter int BITC = 16
) (
  // Clock
  input  wire logic clk,
  // Line
  input  wire logic inv,
  input  wire logic from_dut,
  output logic      to_dut
);
  logic drv = 1'h1;
  assign to_dut = drv ^ inv;
  task automatic bit_out(input logic b);
    drv <= b;
    repeat (BITC) @(posedge clk);
  endtask
  // Start, data LSB first, parity, stop, idle
  task automatic send(input logic [8:0] d, input int n, input logic pe, ev, bad, stp);
    logic p;
    p = ^(d & ((9'h1 << n) - 9'h1)) ^ !ev ^ bad;
    bit_out(1'h0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (pe) bit_out(p);
    bit_out(stp);
    bit_out(1'h1);
  endtask
  // Samples mid-bit after the start edge
  task automatic recv(input int nb, output logic [11:0] d);
    d = 12'hFFF;
    while ((from_dut ^ inv) !== 1'h0) @(posedge clk);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BITC) @(posedge clk);
      d[i] = from_dut ^ inv;
    end
  endtask
endmodule // asu_peer

// file: async_serial_uart_with_handshake_test.sv
`timescale 1ns/100ps
`include "asu_map.svh"
module async_serial_uart_with_handshake_test;
  import asu_pkg::*;
  logic        clk = 1'h0, nrst = 1'h0, tx_en = 1'h0, rx_en = 1'h0, stop2 = 1'h0;
  logic        par_en = 1'h0, par_ev = 1'h0, pol = 1'h0, dli = 1'h0, msb = 1'h0;
  logic        filt = 1'h0, hs_dis = 1'h1, hs_sel = 1'h0, irq_sel = 1'h0, cts = 1'h0;
  logic        tx_valid = 1'h0, rd = 1'h0, xclk = 1'h1;
  logic [2:0]  mode = `ASU_MODE_OFF;
  asu_char_t   tx_data = 9'h000, rbuf, m;
  logic        tx_ready, tbe, tse, rxc, ov, fr, pa, sum, txi, rxi, so, rxd, hso;
  logic [11:0] f;
  logic [7:0]  xe [3] = '{8'h8C, 8'hCE, 8'h31};
  int          err_total = 0, comparisons = 0, cycles = 0, txi_n = 0, n;

  asu_uart DUT (
    .clk(clk), .nrst(nrst), .serial_mode_field(mode), .clock_source_select(1'h0),
    .internal_tap_tick(1'h1), .baud_divisor(8'h00), .stop_bit_select(stop2),
    .parity_enable(par_en), .parity_odd_even_select(par_ev), .pin_polarity_invert(pol),
    .data_logic_invert(dli), .bit_order_select(msb), .open_drain_select(1'h0),
    .rx_filter_enable(filt), .handshake_disable(hs_dis), .handshake_select(hs_sel),
    .tx_irq_source_select(irq_sel), .transmit_enable(tx_en), .rx_enable(rx_en),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .transmit_buffer(tx_data),
    .tx_buffer_empty_flag(tbe), .tx_shift_empty(tse), .receive_buffer(rbuf),
    .rx_complete_flag(rxc), .rx_read(rd), .overrun_flag(ov), .framing_error_flag(fr),
    .parity_error_flag(pa), .error_sum_flag(sum), .tx_irq(txi), .rx_irq_control(rxi),
    .serial_out_pin_o(so), .serial_out_pin_oe(), .serial_in_pin(rxd),
    .transfer_clock_pin(xclk), .handshake_pin_i(cts), .handshake_pin_o(hso),
    .handshake_pin_oe()
  );
  asu_peer peer (.clk(clk), .inv(pol), .from_dut(so), .to_dut(rxd));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (txi === 1'h1) txi_n++;
    if (cycles == 40000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic push(input asu_char_t d);
    @(posedge clk);
    tx_valid <= 1'h1;
    tx_data <= d;
    @(negedge clk);
    while (tx_ready !== 1'h1) @(negedge clk);
    @(posedge clk);
    tx_valid <= 1'h0;
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 600 && rxc !== 1'h1; i++) @(negedge clk);
  endtask
  task automatic ack();
    @(posedge clk);
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
  endtask
  task automatic rx_get(input asu_char_t mk, e);
    wait_rx();
    chk(12'(rbuf & mk), 12'(e));
    ack();
  endtask
  function automatic logic [11:0] frame(input asu_char_t d, input int w, input logic pe, ev);
    logic [11:0] r;
    r = 12'hFFF;
    for (int i = 0; i < w; i++) r[i] = d[i];
    if (pe) r[w] = ^(d & ((9'h1 << w) - 9'h1)) ^ !ev;
    return r;
  endfunction
  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      n = 7 + k;
      m = (9'h1 << n) - 9'h1;
      mode <= `ASU_MODE_7BIT + 3'(k);
      par_en <= (k != 1);
      par_ev <= (k == 0);
      stop2 <= (k == 0);
      filt <= (k == 2);
      tx_en <= 1'h1;
      rx_en <= 1'h1;
      push(9'h15A);
      peer.recv(n + (k != 1) + 1 + (k == 0), f);
      chk(f, frame(9'h15A, n, k != 1, k == 0));
      peer.send(9'h15A, n, k != 1, k == 0, 1'h0, 1'h1);
      rx_get(m, 9'h15A & m);
    end
    stop2 <= 1'h0;
    par_en <= 1'h1;
    par_ev <= 1'h1;
    mode <= `ASU_MODE_8BIT;
    peer.send(9'h055, 8, 1'h1, 1'h1, 1'h1, 1'h1);
    wait_rx();
    chk({ov, fr, pa}, 3'h1);
    ack();
    peer.send(9'h055, 8, 1'h1, 1'h1, 1'h0, 1'h1);
    wait_rx();
    chk({ov, fr, pa}, 3'h0);
    peer.send(9'h055, 8, 1'h1, 1'h1, 1'h0, 1'h1);
    chk({ov, sum}, 2'h3);
    ack();
    peer.send(9'h055, 8, 1'h1, 1'h1, 1'h0, 1'h0);
    wait_rx();
    chk(fr, 1'h1);
    par_en <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      tx_en <= 1'h0;
      rx_en <= 1'h0;
      mode <= `ASU_MODE_OFF;
      msb <= (k == 0);
      dli <= (k == 1);
      pol <= (k == 2);
      repeat (300) @(posedge clk);
      chk({ov, fr, pa, sum}, 4'h0);
      mode <= `ASU_MODE_8BIT;
      tx_en <= 1'h1;
      rx_en <= 1'h1;
      push(9'h031);
      peer.recv(9, f);
      chk(f, {4'hF, xe[k]});
      peer.send(9'h031, 8, 1'h0, 1'h0, 1'h0, 1'h1);
      rx_get(9'h0FF, {1'h0, xe[k]});
    end
    hs_dis <= 1'h0;
    cts <= 1'h1;
    irq_sel <= 1'h1;
    repeat (6) @(posedge clk);
    push(9'h0C3);
    n = txi_n;
    repeat (300) @(posedge clk);
    chk(tse, 1'h1);
    cts <= 1'h0;
    peer.recv(9, f);
    chk(f, {4'hF, 8'hC3});
    chk(12'(txi_n), 12'(n));
    repeat (20) @(posedge clk);
    chk(12'(txi_n), 12'(n + 1));
    hs_sel <= 1'h1;
    repeat (3) @(posedge clk);
    chk(hso, 1'h0);
    xclk <= 1'h0;
    repeat (8) @(posedge clk);
    chk(hso, 1'h1);
    hs_dis <= 1'h1;
    dli <= 1'h0;
    tx_en <= 1'h0;
    for (int k = 0; k < 8; k++) push(9'(k));
    @(negedge clk);
    chk({tx_ready, tbe}, 2'h0);
    @(posedge clk);
    tx_en <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      peer.recv(9, f);
      chk(f, 12'hF00 | 12'(k));
    end
    wrap_up();
  end
endmodule // async_serial_uart_with_handshake_test
